// ### timer_trio_pkg.sv
`default_nettype none

package timer_trio_pkg;

	// Widths and counts
	localparam int DATA_W    = 8;
	localparam int ADDR_W    = 4;
	localparam int NUM_CTR   = 3;
	localparam int PSC_W     = 3;
	localparam int PSC_CNT_W = 7;

	// Register offsets (word index on the plain register port)
	localparam logic [3:0] OFF_SHARED = 4'h0;
	localparam logic [3:0] OFF_CTL0   = 4'h1;
	localparam logic [3:0] OFF_VAL0   = 4'h2;
	localparam logic [3:0] OFF_CTL1   = 4'h3;
	localparam logic [3:0] OFF_VAL1   = 4'h4;
	localparam logic [3:0] OFF_CTL2   = 4'h5;
	localparam logic [3:0] OFF_VAL2   = 4'h6;

	// Field positions
	localparam int EXT_SRC_BIT = 6;
	localparam int MODE_HI_BIT = 7;
	localparam int MODE_LO_BIT = 6;
	localparam int RUN_BIT     = 4;
	localparam int EDGE_BIT    = 3;
	localparam int PSC_HI_BIT  = 2;

	// Reset values
	localparam logic [7:0] SHARED_RST  = 8'h00;
	localparam logic [7:0] CTL0_RST    = 8'h08;
	localparam logic [7:0] CTL1_RST    = 8'h00;
	localparam logic [7:0] CTL2_RST    = 8'h00;
	localparam logic [7:0] PRELOAD_RST = 8'h00;

	// Implemented bits; all others read as zero
	localparam logic [7:0] SHARED_MASK = 8'h40;
	localparam logic [7:0] CTL0_MASK   = 8'hDF;
	localparam logic [7:0] CTL1_MASK   = 8'hD7;
	localparam logic [7:0] CTL2_MASK   = 8'h17;

	// Operating mode codes
	localparam logic [1:0] MODE_PULSE_GEN = 2'h0;
	localparam logic [1:0] MODE_EVENT     = 2'h1;
	localparam logic [1:0] MODE_TIMER     = 2'h2;
	localparam logic [1:0] MODE_PULSE_W   = 2'h3;

	localparam logic [7:0] FULL_COUNT = 8'hFF;

	// One counter control byte
	typedef struct packed {
		logic [1:0] op_mode;
		logic       gap;
		logic       count_run_bit;
		logic       active_edge_sel;
		logic [2:0] prescale_ratio_sel;
	} ctr_control_s;

	// One register port request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} bus_req_s;

	typedef enum {PW_WAIT, PW_COUNT, PW_DONE} pw_state_e;

endpackage

`default_nettype wire

// ### prescale_tick.sv
`default_nettype none

module prescale_tick #(
	parameter int SEL_W = timer_trio_pkg::PSC_W,
	parameter int CNT_W = timer_trio_pkg::PSC_CNT_W
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             run,
	input  wire logic [SEL_W-1:0] sel,
	output logic                  tick
);

	if (CNT_W < (1 << SEL_W) - 1) begin : g_chk
		$error("prescale_tick: CNT_W too small for SEL_W");
	end

	logic [CNT_W-1:0] div_reg;
	logic [CNT_W-1:0] mask;

	// Held at zero while idle so the first tick after start is a full period
	always_ff @(posedge clk) begin
		if (rst || !run) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + 1'b1;
		end
	end

	// Divide by two to the power of sel
	assign mask = CNT_W'((1 << sel) - 1);
	assign tick = run && ((div_reg & mask) == mask);

	property p_undivided;
		@(posedge clk) disable iff (rst) (run && sel == '0) |-> tick;
	endproperty
	a_undivided: assert property (p_undivided) else $error("undivided code did not tick");

	property p_divided_gap;
		@(posedge clk) disable iff (rst) (run && sel != '0 && tick) |=> (!tick || sel == '0);
	endproperty
	a_divided_gap: assert property (p_divided_gap) else $error("divided ticks back to back");

endmodule

`default_nettype wire

// ### count_slice.sv
`default_nettype none

module count_slice #(
	parameter int WIDTH = timer_trio_pkg::DATA_W
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             run,
	input  wire logic             inc,
	input  wire logic             load_wr,
	input  wire logic [WIDTH-1:0] load_data,
	output logic      [WIDTH-1:0] count,
	output logic                  overflow
);

	if (WIDTH < 2) begin : g_chk
		$error("count_slice: WIDTH must be at least 2");
	end

	logic [WIDTH-1:0] preload_reg;
	logic [WIDTH-1:0] count_reg;
	logic             ovf_reg;
	logic             full;

	assign full = (count_reg == {WIDTH{1'b1}});

	// Preload always takes the software value
	always_ff @(posedge clk) begin
		if (rst) begin
			preload_reg <= WIDTH'(timer_trio_pkg::PRELOAD_RST);
		end else if (load_wr) begin
			preload_reg <= load_data;
		end
	end

	// Stopped counter follows a preload write; running one waits for overflow
	always_ff @(posedge clk) begin
		if (rst) begin
			count_reg <= WIDTH'(timer_trio_pkg::PRELOAD_RST);
		end else if (load_wr && !run) begin
			count_reg <= load_data;
		end else if (inc && full) begin
			count_reg <= preload_reg;
		end else if (inc) begin
			count_reg <= count_reg + 1'b1;
		end
	end

	// One cycle request per overflow
	always_ff @(posedge clk) begin
		if (rst) begin
			ovf_reg <= 1'b0;
		end else begin
			ovf_reg <= inc && full;
		end
	end

	assign count    = count_reg;
	assign overflow = ovf_reg;

	property p_reload;
		@(posedge clk) disable iff (rst) (inc && full) |=> (count_reg == $past(preload_reg) && ovf_reg);
	endproperty
	a_reload: assert property (p_reload) else $error("overflow did not reload");

	property p_step;
		@(posedge clk) disable iff (rst) (inc && !full && !(load_wr && !run)) |=> count_reg == $past(count_reg) + 1'b1;
	endproperty
	a_step: assert property (p_step) else $error("count did not step by one");

	property p_stopped_load;
		@(posedge clk) disable iff (rst) (load_wr && !run) |=> count_reg == $past(load_data);
	endproperty
	a_stopped_load: assert property (p_stopped_load) else $error("stopped write missed counter");

	property p_running_load;
		@(posedge clk) disable iff (rst) (load_wr && run && !inc) |=> $stable(count_reg);
	endproperty
	a_running_load: assert property (p_running_load) else $error("running write hit counter");

	property p_single_irq;
		@(posedge clk) disable iff (rst) (ovf_reg && !$past(inc && full)) |-> 1'b0;
	endproperty
	a_single_irq: assert property (p_single_irq) else $error("request without overflow");

endmodule

`default_nettype wire

// ### timer_trio.sv
// Implementation choices: the strobed register port and the address map.
`default_nettype none

module timer_trio (
	input  wire logic       REF_CLK,
	input  wire logic       RESET,
	input  wire logic [3:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output logic      [7:0] RDATA,
	input  wire logic       EVENT_INPUT_PIN,
	input  wire logic       DEBOUNCED_IRQ_SIGNAL,
	output logic      [2:0] OVF_IRQ,
	output logic            PULSE_GEN_TICK
);

	localparam int N = timer_trio_pkg::NUM_CTR;

	// Address match, shared by write decode and checks; the read mux cases on the address directly
	function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
		return a == off;
	endfunction

	timer_trio_pkg::bus_req_s     req;
	logic [7:0]                   shared_reg;
	timer_trio_pkg::ctr_control_s ctl_reg [N];
	logic [7:0]                   rdata_reg;
	logic [7:0]                   rdata_next;
	logic                         pulse_gen_tick_reg;

	logic [N-1:0]                 run;
	logic [N-1:0]                 inc;
	logic                         ctr0_inc;
	logic                         ctr1_inc;
	logic [N-1:0]                 ps_run;
	logic [N-1:0]                 ps_tick;
	logic [N-1:0]                 val_wr;
	logic [N-1:0]                 ovf;
	logic [7:0]                   count [N];

	logic                         ext_src;
	logic                         src_prev_reg;
	logic                         rise;
	logic                         fall;
	logic                         edge_hit;
	logic                         pw_start;
	logic                         pw_stop;
	timer_trio_pkg::pw_state_e    pw_state_reg;
	logic [1:0]                   mode0;
	logic [1:0]                   mode1;

	assign req = '{wr: WR, rd: RD, addr: ADDR, wdata: WDATA};

	// Write strobes for the three value registers
	assign val_wr[0] = req.wr && hit(req.addr, timer_trio_pkg::OFF_VAL0);
	assign val_wr[1] = req.wr && hit(req.addr, timer_trio_pkg::OFF_VAL1);
	assign val_wr[2] = req.wr && hit(req.addr, timer_trio_pkg::OFF_VAL2);

	// Shared control: only the source select lives here, other bits read zero
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			shared_reg <= timer_trio_pkg::SHARED_RST;
		end else if (req.wr && hit(req.addr, timer_trio_pkg::OFF_SHARED)) begin
			shared_reg <= req.wdata & timer_trio_pkg::SHARED_MASK;
		end
	end

	// Counter 0 control; unimplemented bit forced low
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			ctl_reg[0] <= timer_trio_pkg::CTL0_RST;
		end else if (req.wr && hit(req.addr, timer_trio_pkg::OFF_CTL0)) begin
			ctl_reg[0] <= req.wdata & timer_trio_pkg::CTL0_MASK;
		end
	end

	// Counter 1 control; no edge select
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			ctl_reg[1] <= timer_trio_pkg::CTL1_RST;
		end else if (req.wr && hit(req.addr, timer_trio_pkg::OFF_CTL1)) begin
			ctl_reg[1] <= req.wdata & timer_trio_pkg::CTL1_MASK;
		end
	end

	// Counter 2 control; mode bits do not exist, so it can only time
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			ctl_reg[2] <= timer_trio_pkg::CTL2_RST;
		end else if (req.wr && hit(req.addr, timer_trio_pkg::OFF_CTL2)) begin
			ctl_reg[2] <= req.wdata & timer_trio_pkg::CTL2_MASK;
		end
	end

	assign mode0   = ctl_reg[0].op_mode;
	assign mode1   = ctl_reg[1].op_mode;
	assign ext_src = shared_reg[timer_trio_pkg::EXT_SRC_BIT];

	// Run gates, one per counter
	assign run[0] = ctl_reg[0].count_run_bit;
	assign run[1] = ctl_reg[1].count_run_bit;
	assign run[2] = ctl_reg[2].count_run_bit;

	// Prescalers only run where the internal clock is really used
	assign ps_run[0] = run[0] && (mode0 == timer_trio_pkg::MODE_TIMER);
	assign ps_run[1] = run[1] && (mode1 == timer_trio_pkg::MODE_TIMER ||
	                              mode1 == timer_trio_pkg::MODE_PULSE_GEN);
	assign ps_run[2] = run[2];

	// External source history; inputs arrive synchronous, so one stage
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			src_prev_reg <= 1'b0;
		end else begin
			src_prev_reg <= ext_src ? DEBOUNCED_IRQ_SIGNAL : EVENT_INPUT_PIN;
		end
	end

	// Edges of the chosen source; flipping the select can fake one edge
	assign rise = (ext_src ? DEBOUNCED_IRQ_SIGNAL : EVENT_INPUT_PIN) && !src_prev_reg;
	assign fall = !(ext_src ? DEBOUNCED_IRQ_SIGNAL : EVENT_INPUT_PIN) && src_prev_reg;

	// Event edge and pulse window edges from the same select bit
	assign edge_hit = ctl_reg[0].active_edge_sel ? fall : rise;
	assign pw_start = ctl_reg[0].active_edge_sel ? rise : fall;
	assign pw_stop  = ctl_reg[0].active_edge_sel ? fall : rise;

	// Pulse-width window: wait for start edge, count, freeze on stop edge
	always_ff @(posedge REF_CLK) begin
		if (RESET || !run[0] || mode0 != timer_trio_pkg::MODE_PULSE_W) begin
			pw_state_reg <= timer_trio_pkg::PW_WAIT;
		end else begin
			unique case (pw_state_reg)
				timer_trio_pkg::PW_WAIT: begin
					if (pw_start) begin
						pw_state_reg <= timer_trio_pkg::PW_COUNT;
					end
				end
				timer_trio_pkg::PW_COUNT: begin
					if (pw_stop) begin
						pw_state_reg <= timer_trio_pkg::PW_DONE;
					end
				end
				timer_trio_pkg::PW_DONE: begin
					pw_state_reg <= timer_trio_pkg::PW_DONE;
				end
			endcase
		end
	end

	// Counter 0 increment source per mode; code 00 never counts
	always_comb begin
		ctr0_inc = 1'b0;
		if (run[0]) begin
			unique case (mode0)
				timer_trio_pkg::MODE_TIMER:   ctr0_inc = ps_tick[0];
				timer_trio_pkg::MODE_EVENT:   ctr0_inc = edge_hit;
				timer_trio_pkg::MODE_PULSE_W: ctr0_inc = pw_state_reg == timer_trio_pkg::PW_COUNT;
				default:                      ctr0_inc = 1'b0;
			endcase
		end
	end

	// Counter 1 counts prescaled clock in both of its modes
	always_comb begin
		ctr1_inc = 1'b0;
		if (run[1]) begin
			unique case (mode1)
				timer_trio_pkg::MODE_TIMER:     ctr1_inc = ps_tick[1];
				timer_trio_pkg::MODE_PULSE_GEN: ctr1_inc = ps_tick[1];
				default:                        ctr1_inc = 1'b0;
			endcase
		end
	end

	// Counter 2: prescaled system clock only; one driver for the whole vector
	assign inc = {run[2] && ps_tick[2], ctr1_inc, ctr0_inc};

	// Three identical counter and prescaler pairs
	for (genvar i = 0; i < N; i++) begin : g_ctr
		prescale_tick #(
			.SEL_W (timer_trio_pkg::PSC_W),
			.CNT_W (timer_trio_pkg::PSC_CNT_W)
		) u_psc (
			.clk  (REF_CLK),
			.rst  (RESET),
			.run  (ps_run[i]),
			.sel  (ctl_reg[i].prescale_ratio_sel),
			.tick (ps_tick[i])
		);

		count_slice #(
			.WIDTH (timer_trio_pkg::DATA_W)
		) u_cnt (
			.clk       (REF_CLK),
			.rst       (RESET),
			.run       (run[i]),
			.inc       (inc[i]),
			.load_wr   (val_wr[i]),
			.load_data (req.wdata),
			.count     (count[i]),
			.overflow  (ovf[i])
		);
	end

	// Pulse generator trigger, aligned with the counter 1 request
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			pulse_gen_tick_reg <= 1'b0;
		end else begin
			pulse_gen_tick_reg <= inc[1] && count[1] == timer_trio_pkg::FULL_COUNT &&
			                      mode1 == timer_trio_pkg::MODE_PULSE_GEN;
		end
	end

	// Read mux; unmapped offsets answer zero
	always_comb begin
		rdata_next = 8'h00;
		if (req.rd) begin
			unique case (req.addr)
				timer_trio_pkg::OFF_SHARED: rdata_next = shared_reg;
				timer_trio_pkg::OFF_CTL0:   rdata_next = ctl_reg[0];
				timer_trio_pkg::OFF_VAL0:   rdata_next = count[0];
				timer_trio_pkg::OFF_CTL1:   rdata_next = ctl_reg[1];
				timer_trio_pkg::OFF_VAL1:   rdata_next = count[1];
				timer_trio_pkg::OFF_CTL2:   rdata_next = ctl_reg[2];
				timer_trio_pkg::OFF_VAL2:   rdata_next = count[2];
				default:                    rdata_next = 8'h00;
			endcase
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign RDATA          = rdata_reg;
	assign OVF_IRQ        = ovf;
	assign PULSE_GEN_TICK = pulse_gen_tick_reg;

	property p_read_live;
		@(posedge REF_CLK) disable iff (RESET) (RD && hit(ADDR, timer_trio_pkg::OFF_VAL0)) |=> RDATA == $past(count[0]);
	endproperty
	a_read_live: assert property (p_read_live) else $error("read did not return count");

	property p_stopped_hold;
		@(posedge REF_CLK) disable iff (RESET) (!run[0] && !val_wr[0]) |=> $stable(count[0]);
	endproperty
	a_stopped_hold: assert property (p_stopped_hold) else $error("stopped counter moved");

	property p_event_only_edge;
		@(posedge REF_CLK) disable iff (RESET)
			(run[0] && mode0 == timer_trio_pkg::MODE_EVENT && !edge_hit && !val_wr[0]) |=> $stable(count[0]);
	endproperty
	a_event_only_edge: assert property (p_event_only_edge) else $error("event counter moved without edge");

	property p_debounced_rise;
		@(posedge REF_CLK) disable iff (RESET)
			(run[0] && mode0 == timer_trio_pkg::MODE_EVENT && ext_src && !ctl_reg[0].active_edge_sel &&
			 DEBOUNCED_IRQ_SIGNAL && !src_prev_reg && count[0] != timer_trio_pkg::FULL_COUNT && !val_wr[0])
			|=> count[0] == $past(count[0]) + 8'h01;
	endproperty
	a_debounced_rise: assert property (p_debounced_rise) else $error("debounced rise not counted");

	property p_no_mode_idle;
		@(posedge REF_CLK) disable iff (RESET) (mode0 == timer_trio_pkg::MODE_PULSE_GEN) |-> !inc[0];
	endproperty
	a_no_mode_idle: assert property (p_no_mode_idle) else $error("counter 0 counts in code 00");

	property p_irq_pulse;
		@(posedge REF_CLK) disable iff (RESET)
			(OVF_IRQ[2] && count[2] != timer_trio_pkg::FULL_COUNT) |=> !OVF_IRQ[2];
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("request longer than one cycle");

	property p_gen_tick;
		@(posedge REF_CLK) disable iff (RESET) PULSE_GEN_TICK |-> OVF_IRQ[1];
	endproperty
	a_gen_tick: assert property (p_gen_tick) else $error("trigger without counter 1 overflow");

endmodule

`default_nettype wire

// ### event_source_model.sv
`default_nettype none

module event_source_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       go,
	input  wire logic       line_sel,
	input  wire logic [3:0] toggles,
	input  wire logic [7:0] gap,
	output logic            pin,
	output logic            dbn,
	output logic            busy
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [3:0] left_reg;
	logic [7:0] wait_reg;

	// Burst of level toggles on one line, gap plus one cycles apart
	// Lines keep their level between bursts, like a slow switch source
	always_ff @(posedge clk) begin
		if (rst) begin
			pin      <= 1'b0;
			dbn      <= 1'b0;
			busy     <= 1'b0;
			left_reg <= 4'h0;
			wait_reg <= 8'h00;
		end else if (go && !busy) begin
			busy     <= 1'b1;
			left_reg <= toggles;
			wait_reg <= gap;
		end else if (busy) begin
			if (wait_reg != 8'h00) begin
				wait_reg <= wait_reg - 8'h01;
			end else if (left_reg != 4'h0) begin
				if (line_sel) begin
					dbn <= ~dbn;
				end else begin
					pin <= ~pin;
				end
				left_reg <= left_reg - 4'h1;
				wait_reg <= gap;
			end else begin
				busy <= 1'b0;
			end
		end
	end

endmodule

`default_nettype wire

// ### timer_trio_tb.sv
`default_nettype none

module timer_trio_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic       ref_clk  = 1'b0;
	logic       reset    = 1'b1;
	logic [3:0] addr     = 4'h0;
	logic [7:0] wdata    = 8'h00;
	logic       wr       = 1'b0;
	logic       rd       = 1'b0;
	logic [7:0] rdata;
	logic       ev_pin;
	logic       ev_dbn;
	logic [2:0] ovf_irq;
	logic       pg_tick;
	logic       go       = 1'b0;
	logic       line_sel = 1'b0;
	logic [3:0] toggles  = 4'h0;
	logic [7:0] gap      = 8'h00;
	logic       busy;
	logic [1:0] lvl      = 2'b00;
	int         err_count   = 0;
	int         checks_done = 0;
	int         cyc         = 0;
	int         tick_cnt    = 0;
	int         irq_cnt [3] = '{0, 0, 0};

	timer_trio timer_trio_inst (
		.REF_CLK             (ref_clk),
		.RESET               (reset),
		.ADDR                (addr),
		.WDATA               (wdata),
		.WR                  (wr),
		.RD                  (rd),
		.RDATA               (rdata),
		.EVENT_INPUT_PIN     (ev_pin),
		.DEBOUNCED_IRQ_SIGNAL(ev_dbn),
		.OVF_IRQ             (ovf_irq),
		.PULSE_GEN_TICK      (pg_tick)
	);

	event_source_model event_source_model_inst (
		.clk     (ref_clk),
		.rst     (reset),
		.go      (go),
		.line_sel(line_sel),
		.toggles (toggles),
		.gap     (gap),
		.pin     (ev_pin),
		.dbn     (ev_dbn),
		.busy    (busy)
	);

	always #5 ref_clk = ~ref_clk;

	// Cycle count and request tallies, sampled before the edge lands
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		for (int i = 0; i < 3; i++) begin
			if (ovf_irq[i] === 1'b1) irq_cnt[i] <= irq_cnt[i] + 1;
		end
		if (pg_tick === 1'b1) tick_cnt <= tick_cnt + 1;
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic stop_test();
		if (err_count == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask

	// Data stand one cycle only, so the following cycle must read back zero
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1;
		v = rdata;
		@(posedge ref_clk);
		#1;
		check("read data release", 16'(rdata), 16'h0000);
	endtask

	task automatic expect_reg(input string what, input logic [3:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rd_reg(a, v);
		check(what, 16'(v), 16'(exp));
	endtask

	// Bounded wait for one counter's overflow request
	task automatic wait_irq(input int i, output int t);
		t = 0;
		for (int k = 0; k < 5000; k++) begin
			@(posedge ref_clk);
			#1;
			if (ovf_irq[i] === 1'b1) begin
				t = cyc;
				return;
			end
		end
		check("overflow request seen", 16'h0000, 16'h0001);
	endtask

	task automatic toggle(input logic s, input logic [3:0] n, input logic [7:0] g);
		int k;
		@(posedge ref_clk);
		line_sel <= s;
		toggles  <= n;
		gap      <= g;
		go       <= 1'b1;
		@(posedge ref_clk);
		go <= 1'b0;
		// Model raises busy at this edge; look only once it has landed
		@(posedge ref_clk);
		k = 0;
		while (busy !== 1'b0 && k < 4000) begin
			@(posedge ref_clk);
			k++;
		end
		lvl[s] = lvl[s] ^ n[0];
		// Room for input sampling and edge detection to settle
		repeat (3) @(posedge ref_clk);
	endtask

	// Overflow spacing from preload FC is four increments of the prescaled clock
	task automatic period(input logic [3:0] c, input logic [7:0] ctl, input int i, input logic [15:0] exp);
		int t1;
		int t2;
		int n0;
		int p0;
		wr_reg(c, 8'h00);
		wr_reg(c + 4'h1, 8'hFC);
		wr_reg(c, ctl);
		wait_irq(i, t1);
		n0 = irq_cnt[i];
		p0 = tick_cnt;
		wait_irq(i, t2);
		check("overflow period", 16'(t2 - t1), exp);
		check("requests per overflow", 16'(irq_cnt[i] - n0), 16'h0001);
		check("pulse gen ticks", 16'(tick_cnt - p0), (i == 1 && ctl[7:6] == 2'b00) ? 16'h0001 : 16'h0000);
		wr_reg(c, 8'h00);
	endtask

	task automatic t_regs();
		logic [7:0] rv [7] = '{8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		logic [3:0] ca [6] = '{4'h0, 4'h1, 4'h3, 4'h5, 4'h7, 4'hF};
		logic [7:0] cm [6] = '{8'h40, 8'hDF, 8'hD7, 8'h17, 8'h00, 8'h00};
		for (int a = 0; a < 16; a++) expect_reg("reset value", a[3:0], (a < 7) ? rv[a] : 8'h00);
		for (int a = 2; a < 7; a += 2) begin
			wr_reg(a[3:0], 8'hFF);
			expect_reg("stopped load", a[3:0], 8'hFF);
		end
		for (int a = 0; a < 6; a++) begin
			wr_reg(ca[a], 8'hFF);
			expect_reg("control bits", ca[a], cm[a]);
			wr_reg(ca[a], 8'h00);
		end
	endtask

	// Counter 2 at the slowest ratio: preload written while running waits for overflow
	task automatic t_reload();
		int t;
		logic [7:0] v;
		wr_reg(4'h6, 8'hF0);
		wr_reg(4'h5, 8'h17);
		wr_reg(4'h6, 8'h20);
		expect_reg("count after running write", 4'h6, 8'hF0);
		wait_irq(2, t);
		expect_reg("count after overflow", 4'h6, 8'h20);
		wr_reg(4'h5, 8'h00);
		rd_reg(4'h6, v);
		repeat (300) @(posedge ref_clk);
		expect_reg("stopped count holds", 4'h6, v);
		wr_reg(4'h6, 8'h00);
		expect_reg("cleared preload", 4'h6, 8'h00);
	endtask

	// Counter 0 event mode on both sources and both edges, prescaler at /128
	task automatic t_event();
		int rise;
		int n0;
		for (int s = 0; s < 2; s++) begin
			for (int e = 0; e < 2; e++) begin
				wr_reg(4'h0, {1'b0, s[0], 6'h00});
				wr_reg(4'h1, 8'h00);
				wr_reg(4'h2, 8'h00);
				wr_reg(4'h1, {4'h5, e[0], 3'b111});
				rise = lvl[s] ? 2 : 3;
				toggle(s[0], 4'h5, 8'h03);
				toggle(!s[0], 4'h3, 8'h03);
				expect_reg("event count", 4'h2, (e == 1) ? 8'(5 - rise) : 8'(rise));
			end
		end
		wr_reg(4'h0, 8'h00);
		wr_reg(4'h1, 8'h00);
		wr_reg(4'h2, 8'h00);
		wr_reg(4'h1, 8'h17);
		toggle(1'b0, 4'h4, 8'h02);
		expect_reg("no mode no count", 4'h2, 8'h00);
		wr_reg(4'h1, 8'h00);
		wr_reg(4'h2, 8'hFE);
		wr_reg(4'h1, 8'h50);
		n0 = irq_cnt[0];
		toggle(1'b0, 4'h4, 8'h03);
		expect_reg("event wrap reload", 4'h2, 8'hFE);
		check("event overflow requests", 16'(irq_cnt[0] - n0), 16'h0001);
	endtask

	// Width mode on both edge selects: start edge, stop edge, then the value freezes
	task automatic t_width();
		logic [7:0] v;
		for (int e = 0; e < 2; e++) begin
			if (lvl[0] == e[0]) toggle(1'b0, 4'h1, 8'h02);
			wr_reg(4'h0, 8'h00);
			wr_reg(4'h1, 8'h00);
			wr_reg(4'h2, 8'h00);
			wr_reg(4'h1, 8'hD0 | {4'h0, e[0], 3'b000});
			toggle(1'b0, 4'h2, 8'd40);
			rd_reg(4'h2, v);
			check("pulse width", 16'(v >= 8'd39 && v <= 8'd43), 16'h0001);
			toggle(1'b0, 4'h2, 8'd10);
			expect_reg("width frozen", 4'h2, v);
			wr_reg(4'h1, 8'h00);
		end
	endtask

	task automatic t_timers();
		for (int n = 0; n < 8; n++) period(4'h3, 8'h90 | 8'(n), 1, 16'(4 << n));
		period(4'h3, 8'h12, 1, 16'h0010);
		period(4'h5, 8'h10, 2, 16'h0004);
		period(4'h5, 8'h13, 2, 16'h0020);
		period(4'h1, 8'h92, 0, 16'h0010);
		wr_reg(4'h3, 8'h00);
		wr_reg(4'h4, 8'hFE);
		wr_reg(4'h3, 8'h50);
		repeat (20) @(posedge ref_clk);
		expect_reg("ctr1 no mode", 4'h4, 8'hFE);
	endtask

	// Watchdog: the whole run needs well under 20k cycles
	initial begin
		#400000;
		err_count++;
		stop_test();
	end

	initial begin
		repeat (6) @(posedge ref_clk);
		reset <= 1'b0;
		t_regs();
		t_reload();
		t_event();
		t_width();
		t_timers();
		stop_test();
	end

endmodule

`default_nettype wire
